// *** hw/epcs_pkg.sv ***
// Constants for the exception pend control and status block
package epcs_pkg;
    localparam logic [11:0] OFF_ICS     = 12'hD04;
    localparam logic [11:0] OFF_IRQ_ST  = 12'hD80;
    localparam logic [11:0] OFF_IRQ_MSK = 12'hD84;
    localparam int BIT_DS_SET   = 28;
    localparam int BIT_DS_CLR   = 27;
    localparam int BIT_TK_SET   = 26;
    localparam int BIT_TK_CLR   = 25;
    localparam int BIT_HALT_IRQ = 23;
    localparam int BIT_ANY_PEND = 22;
    localparam int EVT_W        = 2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : epcs_pkg

// *** hw/epcs_pend_bit.sv ***
// One pending flag with set, clear and handler-entry clear
`timescale 1ns/1ps
module epcs_pend_bit (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic set_req,
    input  wire logic clr_req,
    input  wire logic entry_clr,
    output logic      pend
);
    logic next_pend;

    always_comb
    begin
        next_pend = pend;
        if (clr_req || entry_clr)
            next_pend = 1'b0;
        // Set wins so a simultaneous set is not lost; both at once is unpredictable anyway
        if (set_req)
            next_pend = 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pend <= 1'b0;
        else
            pend <= next_pend;
    end
endmodule : epcs_pend_bit

// *** hw/epcs_top.sv ***
// Interrupt control and state upper field with AXI4-Lite access
`timescale 1ns/1ps
module epcs_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_awaddr,
    input  wire logic [2:0]  s_awprot,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [11:0] s_araddr,
    input  wire logic [2:0]  s_arprot,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    input  wire logic        debug_halted,
    input  wire logic        halt_release_irq,
    input  wire logic        ext_irq_pending,
    input  wire logic        enter_deferred_service,
    input  wire logic        enter_system_tick,
    output logic             deferred_service_pending,
    output logic             system_tick_pending,
    output logic             irq
);
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic        aw_priv;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  ev_status;
    logic [1:0]  ev_mask;
    logic        next_aw_held;
    logic        next_w_held;
    logic [11:0] next_aw_addr;
    logic        next_aw_priv;
    logic [31:0] next_w_data;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;
    logic        next_rvalid;
    logic [1:0]  next_rresp;
    logic [31:0] next_rdata;
    logic [1:0]  next_ev_status;
    logic [1:0]  next_ev_mask;
    logic        next_irq;
    logic        wr_fire;
    logic        wr_ics;
    logic        rd_fire;
    logic        rd_priv;
    logic        ds_pend;
    logic        tk_pend;
    logic        ds_set;
    logic        ds_clr;
    logic        tk_set;
    logic        tk_clr;
    logic [31:0] ics_word;
    logic [1:0]  ev_pulse;
    logic        ics_rd;

    // Write fires once address and data are both held and no response is outstanding
    assign wr_fire = aw_held && w_held && !s_bvalid;
    assign wr_ics  = wr_fire && aw_priv && (aw_addr == epcs_pkg::OFF_ICS) && w_strb[3];
    assign ds_set  = wr_ics && w_data[epcs_pkg::BIT_DS_SET];
    assign ds_clr  = wr_ics && w_data[epcs_pkg::BIT_DS_CLR];
    assign tk_set  = wr_ics && w_data[epcs_pkg::BIT_TK_SET];
    assign tk_clr  = wr_ics && w_data[epcs_pkg::BIT_TK_CLR];

    epcs_pend_bit u_ds (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .set_req   (ds_set),
        .clr_req   (ds_clr),
        .entry_clr (enter_deferred_service),
        .pend      (ds_pend)
    );

    epcs_pend_bit u_tk (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .set_req   (tk_set),
        .clr_req   (tk_clr),
        .entry_clr (enter_system_tick),
        .pend      (tk_pend)
    );

    // Clear-pending bits are write-only; returning zero is a safe choice for unknown
    always_comb
    begin
        ics_word = epcs_pkg::RESET_WORD;
        ics_word[epcs_pkg::BIT_DS_SET]   = ds_pend;
        ics_word[epcs_pkg::BIT_TK_SET]   = tk_pend;
        ics_word[epcs_pkg::BIT_HALT_IRQ] = debug_halted && halt_release_irq;
        // Pending summary excludes NMI and faults by input definition
        ics_word[epcs_pkg::BIT_ANY_PEND] = ext_irq_pending || ds_pend || tk_pend;
    end

    // Events: bit 0 deferred service became pending, bit 1 tick became pending
    assign ev_pulse = {tk_set && !tk_pend, ds_set && !ds_pend};
    assign rd_fire  = s_arvalid && s_arready;
    assign rd_priv  = s_arprot[0];
    // Privileged read of the control word, used only by the checks below
    assign ics_rd   = rd_fire && rd_priv && (s_araddr == epcs_pkg::OFF_ICS);

    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_aw_priv = aw_priv;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_bvalid;
        next_bresp   = s_bresp;
        next_rvalid  = s_rvalid;
        next_rresp   = s_rresp;
        next_rdata   = s_rdata;
        next_ev_mask = ev_mask;
        next_ev_status = ev_status;
        if (s_awvalid && s_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_awaddr;
            next_aw_priv = s_awprot[0];
        end
        if (s_wvalid && s_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_wdata;
            next_w_strb = s_wstrb;
        end
        if (wr_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = epcs_pkg::RESP_OKAY;
            if (!aw_priv)
                next_bresp = epcs_pkg::RESP_SLVERR;
            else if (aw_addr == epcs_pkg::OFF_IRQ_MSK)
                next_ev_mask = w_data[1:0];
            else if (aw_addr != epcs_pkg::OFF_ICS && aw_addr != epcs_pkg::OFF_IRQ_ST)
                next_bresp = epcs_pkg::RESP_SLVERR;
        end
        else if (s_bvalid && s_bready)
            next_bvalid = 1'b0;
        if (rd_fire)
        begin
            next_rvalid = 1'b1;
            next_rresp  = epcs_pkg::RESP_OKAY;
            next_rdata  = epcs_pkg::RESET_WORD;
            if (!rd_priv)
                next_rresp = epcs_pkg::RESP_SLVERR;
            else if (s_araddr == epcs_pkg::OFF_ICS)
                next_rdata = ics_word;
            else if (s_araddr == epcs_pkg::OFF_IRQ_ST)
            begin
                next_rdata = {30'h0000_0000, ev_status};
                next_ev_status = 2'h0;
            end
            else if (s_araddr == epcs_pkg::OFF_IRQ_MSK)
                next_rdata = {30'h0000_0000, ev_mask};
            else
                next_rresp = epcs_pkg::RESP_SLVERR;
        end
        else if (s_rvalid && s_rready)
            next_rvalid = 1'b0;
        // New events win over the read-clear
        next_ev_status = next_ev_status | ev_pulse;
        next_irq = |(next_ev_status & next_ev_mask);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held   <= 1'b0;
            aw_addr   <= 12'h000;
            aw_priv   <= 1'b0;
            w_held    <= 1'b0;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            s_bvalid  <= 1'b0;
            s_bresp   <= 2'h0;
            s_rvalid  <= 1'b0;
            s_rresp   <= 2'h0;
            s_rdata   <= 32'h0000_0000;
            ev_status <= 2'h0;
            ev_mask   <= 2'h0;
            irq       <= 1'b0;
            s_awready <= 1'b0;
            s_wready  <= 1'b0;
            s_arready <= 1'b0;
            deferred_service_pending <= 1'b0;
            system_tick_pending      <= 1'b0;
        end
        else
        begin
            aw_held   <= next_aw_held;
            aw_addr   <= next_aw_addr;
            aw_priv   <= next_aw_priv;
            w_held    <= next_w_held;
            w_data    <= next_w_data;
            w_strb    <= next_w_strb;
            s_bvalid  <= next_bvalid;
            s_bresp   <= next_bresp;
            s_rvalid  <= next_rvalid;
            s_rresp   <= next_rresp;
            s_rdata   <= next_rdata;
            ev_status <= next_ev_status;
            ev_mask   <= next_ev_mask;
            irq       <= next_irq;
            // Ready only while the holding slot is free and will stay free next cycle
            s_awready <= !next_aw_held && !(s_awvalid && s_awready);
            s_wready  <= !next_w_held && !(s_wvalid && s_wready);
            s_arready <= !next_rvalid && !rd_fire;
            deferred_service_pending <= next_pend_ds();
            system_tick_pending      <= next_pend_tk();
        end
    end

    function automatic logic next_pend_ds();
        next_pend_ds = ds_set || (ds_pend && !ds_clr && !enter_deferred_service);
    endfunction : next_pend_ds

    function automatic logic next_pend_tk();
        next_pend_tk = tk_set || (tk_pend && !tk_clr && !enter_system_tick);
    endfunction : next_pend_tk

    a_ds_set_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        ds_set |=> ds_pend)
        else $error("deferred set lost");
    a_ds_only_sw: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ds_pend) |-> $past(ds_set))
        else $error("deferred pend without write");
    a_ds_no_other: assert property (@(posedge aclk) disable iff (!aresetn)
        !ds_set && !ds_pend |=> !ds_pend)
        else $error("deferred pend from another path");
    a_ds_clr_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        ds_clr && !ds_set |=> !ds_pend)
        else $error("deferred clear failed");
    a_tk_set_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        tk_set |=> tk_pend ##0 system_tick_pending)
        else $error("tick set lost");
    a_tk_clr_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        tk_clr && !tk_set |=> !tk_pend)
        else $error("tick clear failed");
    a_tk_zero_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_ics && !w_data[epcs_pkg::BIT_TK_SET] && !w_data[epcs_pkg::BIT_TK_CLR]
        && !enter_system_tick |=> $stable(tk_pend))
        else $error("zero write changed tick state");
    a_clr_bits_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire |=> !s_rdata[epcs_pkg::BIT_DS_CLR] && !s_rdata[epcs_pkg::BIT_TK_CLR])
        else $error("write-only bit read nonzero");
    a_halt_irq_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        ics_rd && !debug_halted |=> !s_rdata[epcs_pkg::BIT_HALT_IRQ])
        else $error("halt bit outside debug");
    a_halt_irq_on: assert property (@(posedge aclk) disable iff (!aresetn)
        ics_rd && debug_halted && halt_release_irq |=> s_rdata[epcs_pkg::BIT_HALT_IRQ])
        else $error("halt bit missing in debug");
    a_any_pend_bit: assert property (@(posedge aclk) disable iff (!aresetn)
        ics_rd && (ds_pend || ext_irq_pending) |=> s_rdata[epcs_pkg::BIT_ANY_PEND])
        else $error("pending summary wrong");
    a_tk_any_pend: assert property (@(posedge aclk) disable iff (!aresetn)
        ics_rd && tk_pend |=> s_rdata[epcs_pkg::BIT_ANY_PEND])
        else $error("pending summary misses tick");
    a_any_pend_none: assert property (@(posedge aclk) disable iff (!aresetn)
        ics_rd && !ds_pend && !tk_pend && !ext_irq_pending |=> !s_rdata[epcs_pkg::BIT_ANY_PEND])
        else $error("pending summary set with nothing pending");
    a_resv_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire |=> s_rdata[24] == 1'b0 && s_rdata[21:19] == 3'h0)
        else $error("reserved set");
    a_unpriv_rej: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && !aw_priv |=> s_bvalid && s_bresp == epcs_pkg::RESP_SLVERR && $stable(ds_pend))
        else $error("unprivileged write accepted");
    a_unpriv_rd: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && !rd_priv |=> s_rvalid && s_rresp == epcs_pkg::RESP_SLVERR && s_rdata == 32'h0)
        else $error("unprivileged read accepted");
    a_entry_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        enter_system_tick && !tk_set |=> !tk_pend)
        else $error("entry did not clear");
    a_ds_entry_clr: assert property (@(posedge aclk) disable iff (!aresetn)
        enter_deferred_service && !ds_set |=> !ds_pend)
        else $error("deferred entry did not clear");
    a_pend_outs: assert property (@(posedge aclk) disable iff (!aresetn)
        deferred_service_pending == ds_pend && system_tick_pending == tk_pend)
        else $error("pending outputs differ from flags");
endmodule : epcs_top

// *** dv/tb_top.sv ***
// Self-checking testbench for the exception pend control and status block
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [31:0] w; logic ds; logic tk;} epcs_row_t;
    logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic        debug_halted, halt_release_irq, ext_irq_pending;
    logic        enter_deferred_service, enter_system_tick;
    logic [11:0] s_awaddr, s_araddr;
    logic [2:0]  s_awprot, s_arprot;
    logic [31:0] s_wdata, data;
    logic [3:0]  s_wstrb;
    logic [1:0]  resp;
    wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    wire         deferred_service_pending, system_tick_pending;
    wire  [1:0]  s_bresp, s_rresp;
    wire  [31:0] s_rdata;
    int          num_errors, check_count;
    // Row order matters: each row starts from the state the previous one left
    epcs_row_t   rows [7] = '{'{32'h1000_0000, 1'h1, 1'h0}, '{32'h0000_0000, 1'h1, 1'h0},
        '{32'h0538_0000, 1'h1, 1'h1}, '{32'h0800_0000, 1'h0, 1'h1},
        '{32'h0200_0000, 1'h0, 1'h0}, '{32'h1400_0000, 1'h1, 1'h1},
        '{32'h0A00_0000, 1'h0, 1'h0}};

    epcs_top dut (.aclk, .aresetn, .s_awaddr, .s_awprot, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arprot,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .debug_halted,
        .halt_release_irq, .ext_irq_pending, .enter_deferred_service, .enter_system_tick,
        .deferred_service_pending, .system_tick_pending, .irq);

    always #50 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [11:0] a, input logic [2:0] p, input logic [31:0] d);
        @(posedge aclk);
        s_awaddr <= a;
        s_awprot <= p;
        s_wdata <= d;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        s_bready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (s_awready === 1'h1) s_awvalid <= 1'h0;
            if (s_wready === 1'h1) s_wvalid <= 1'h0;
            if (s_bvalid === 1'h1) break;
        end
        resp = s_bresp;
        s_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [2:0] p);
        @(posedge aclk);
        s_araddr <= a;
        s_arprot <= p;
        s_arvalid <= 1'h1;
        s_rready <= 1'h1;
        forever
        begin
            @(posedge aclk);
            if (s_arready === 1'h1) s_arvalid <= 1'h0;
            if (s_rvalid === 1'h1) break;
        end
        resp = s_rresp;
        data = s_rdata;
        s_rready <= 1'h0;
    endtask : rd

    // Only bits 28:19 belong to this block; the rest of the word is not judged
    task automatic ck_ics(input logic ds, input logic tk, input logic h, input logic ext);
        rd(epcs_pkg::OFF_ICS, 3'h1);
        chk("ics_rresp", {30'h0, epcs_pkg::RESP_OKAY}, {30'h0, resp});
        chk("ics", {3'h0, ds, 1'h0, tk, 1'h0, 1'h0, h, ds | tk | ext, 22'h0},
            data & 32'h1FF8_0000);
    endtask : ck_ics

    task automatic pulse_and_check(input logic which, input logic ds, input logic tk);
        @(posedge aclk);
        enter_deferred_service <= ~which;
        enter_system_tick <= which;
        @(posedge aclk);
        enter_deferred_service <= 1'h0;
        enter_system_tick <= 1'h0;
        @(posedge aclk);
        chk("pend", {30'h0, ds, tk}, {30'h0, deferred_service_pending, system_tick_pending});
    endtask : pulse_and_check

    initial
    begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        give_verdict();
    end

    initial
    begin
        {aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {debug_halted, ext_irq_pending, enter_deferred_service, enter_system_tick} = '0;
        {s_awaddr, s_araddr, s_awprot, s_arprot, s_wdata} = '0;
        halt_release_irq = 1'h1;
        s_wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rows[i])
        begin
            wr(epcs_pkg::OFF_ICS, 3'h1, rows[i].w);
            chk("bresp", {30'h0, epcs_pkg::RESP_OKAY}, {30'h0, resp});
            chk("pend", {30'h0, rows[i].ds, rows[i].tk},
                {30'h0, deferred_service_pending, system_tick_pending});
            ck_ics(rows[i].ds, rows[i].tk, 1'h0, 1'h0);
        end
        @(posedge aclk);
        debug_halted <= 1'h1;
        ck_ics(1'h0, 1'h0, 1'h1, 1'h0);
        halt_release_irq <= 1'h0;
        ck_ics(1'h0, 1'h0, 1'h0, 1'h0);
        ext_irq_pending <= 1'h1;
        ck_ics(1'h0, 1'h0, 1'h0, 1'h1);
        ext_irq_pending <= 1'h0;
        wr(epcs_pkg::OFF_ICS, 3'h0, 32'h1000_0000);
        chk("unpriv_bresp", {30'h0, epcs_pkg::RESP_SLVERR}, {30'h0, resp});
        chk("unpriv_pend", 32'h0, {31'h0, deferred_service_pending});
        rd(epcs_pkg::OFF_ICS, 3'h0);
        chk("unpriv_rresp", {30'h0, epcs_pkg::RESP_SLVERR}, {30'h0, resp});
        chk("unpriv_rdata", 32'h0, data);
        rd(12'h100, 3'h1);
        chk("unmapped_rresp", {30'h0, epcs_pkg::RESP_SLVERR}, {30'h0, resp});
        chk("unmapped_rdata", 32'h0, data);
        wr(epcs_pkg::OFF_IRQ_MSK, 3'h1, 32'h0000_0003);
        rd(epcs_pkg::OFF_IRQ_ST, 3'h1);
        wr(epcs_pkg::OFF_ICS, 3'h1, 32'h1000_0000);
        repeat (2) @(posedge aclk);
        chk("irq_set", 32'h1, {31'h0, irq});
        rd(epcs_pkg::OFF_IRQ_ST, 3'h1);
        chk("status", 32'h1, data);
        repeat (3) @(posedge aclk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(epcs_pkg::OFF_IRQ_MSK, 3'h1, 32'h0000_0000);
        wr(epcs_pkg::OFF_ICS, 3'h1, 32'h0400_0000);
        repeat (2) @(posedge aclk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd(epcs_pkg::OFF_IRQ_ST, 3'h1);
        chk("status", 32'h2, data);
        pulse_and_check(1'h0, 1'h0, 1'h1);
        pulse_and_check(1'h1, 1'h0, 1'h0);
        pulse_and_check(1'h0, 1'h0, 1'h0);
        // Control word writes without the top byte lane are dropped
        s_wstrb <= 4'h7;
        wr(epcs_pkg::OFF_ICS, 3'h1, 32'h1000_0000);
        s_wstrb <= 4'hF;
        chk("strb_bresp", {30'h0, epcs_pkg::RESP_OKAY}, {30'h0, resp});
        chk("strb_ignored", 32'h0, {31'h0, deferred_service_pending});
        wr(epcs_pkg::OFF_ICS, 3'h1, 32'h1400_0000);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("rst_outs", 32'h0, {29'h0, deferred_service_pending, system_tick_pending, irq});
        ck_ics(1'h0, 1'h0, 1'h0, 1'h0);
        give_verdict();
    end
endmodule : tb_top
